// ==== design/sfg_defines.svh ====
// Constants of the serial flash bus front end and write guard.
`ifndef SFG_DEFINES_SVH
`define SFG_DEFINES_SVH
// Instruction codes.
`define SFG_OP_UNLOCK 8'h06
`define SFG_OP_RELOCK 8'h04
`define SFG_OP_STAT_RD 8'h05
`define SFG_OP_STAT_WR 8'h01
`define SFG_OP_PROG 8'h02
`define SFG_OP_SECT_ER 8'h20
`define SFG_OP_BLK_ER 8'hd8
`define SFG_OP_CHIP_ER_A 8'hc7
`define SFG_OP_CHIP_ER_B 8'h60
`define SFG_OP_SLEEP 8'hb9
`define SFG_OP_WAKE 8'hab
`define SFG_OP_DUAL_RD 8'h3b
// Status field positions.
`define SFG_SR_BUSY 0
`define SFG_SR_UNLOCK 1
`define SFG_SR_GUARD_LO 2
`define SFG_SR_GUARD_HI 4
`define SFG_SR_LOW_END 5
`define SFG_SR_RSVD 6
`define SFG_SR_LOCK 7
`define SFG_SR_WR_MASK 8'hbc
`define SFG_SR_RESET 8'h00
// Bit counts of the serial frames.
`define SFG_STAT_START_BITS 12'd8
`define SFG_DUAL_START_BITS 12'd40
// Timing.
`define SFG_CLK_MHZ 25
`define SFG_PUW_US 10
`define SFG_PUW_CYC (`SFG_PUW_US * `SFG_CLK_MHZ)
`define SFG_OP_US 20
`define SFG_OP_CYC (`SFG_OP_US * `SFG_CLK_MHZ)
`endif

// ==== design/sfg_guard.sv ====
// Region guard decode: is a block inside the guarded span.
`timescale 1ns/1ns
module sfg_guard #(
  parameter int BLOCKS = 16
) (
  // Guard code and end select.
  input wire logic [2:0] i_guard,
  input wire logic i_from_low,
  // Block index of the target address.
  input wire logic [3:0] i_block,
  // Results.
  output logic o_hit,
  output logic o_any
);
  logic [4:0] span;
  logic [4:0] blk;

  // Number of guarded blocks for a guard code on this part size.
  function automatic logic [4:0] sfg_span(input logic [2:0] g);
    logic all;
    logic [2:0] c;
    all = 1'b0;
    c = g;
    if (BLOCKS == 16)
    begin
      all = (g >= 3'd5);
    end
    else if (BLOCKS == 8)
    begin
      all = g[2];
      c = {1'b0, g[1:0]};
    end
    else if (BLOCKS == 4)
    begin
      all = (g[1:0] == 2'b11);
      c = {1'b0, g[1:0]};
    end
    else
    begin
      all = g[1];
      c = {1'b0, g[1:0]};
    end
    if (all)
      sfg_span = 5'(BLOCKS);
    else if (c == 3'd0)
      sfg_span = 5'd0;
    else
      sfg_span = 5'(5'd1 << (c - 3'd1));
  endfunction : sfg_span

  // Span counts from the top end or from block zero.
  always_comb
  begin
    span = sfg_span(i_guard);
    blk = {1'b0, i_block & 4'(BLOCKS - 1)};
    o_any = (span != 5'd0);
    o_hit = i_from_low ? (blk < span) : (blk >= 5'(BLOCKS) - span);
  end
endmodule : sfg_guard

// ==== design/sfg_pkg.sv ====
// Types of the serial flash bus front end and write guard.
package sfg_pkg;
  // Protection state machine, Gray coded along inhibit, ready, busy, sleep.
  typedef enum logic [1:0] {
    sfg_st_inhibit = 2'b00,
    sfg_st_ready = 2'b01,
    sfg_st_busy = 2'b11,
    sfg_st_sleep = 2'b10
  } sfg_state_t;
endpackage : sfg_pkg

// ==== design/sfg_sync.sv ====
// Two flip-flop synchroniser for quasi-static levels.
`timescale 1ns/1ns
module sfg_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock.
  input wire logic i_clk,
  // Level from another domain.
  input wire logic [WIDTH-1:0] i_d,
  // Synchronised level.
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk)
  begin
    meta_reg <= i_d;
    o_q <= meta_reg;
  end
endmodule : sfg_sync

// ==== design/sfg_top.sv ====
// Serial flash bus front end with status register and write guard.
//
// Behaviour
// - Works with clock idling low or high.
// - Input bits sampled on rising clock edges.
// - Output bits change on falling clock edges.
// - Dual output only for dual fast read.
// - Pause starts per clock level at pin fall.
// - Pause ends per clock level at pin rise.
// - Paused: output floats, inputs ignored, state kept.
// - Low supply: no write, unlock or sleep performed; status and dual reads still served.
// - Write instructions refused during power-up delay.
// - Unlock latch needed before any write instruction.
// - Unlock latch set and cleared by events.
// - Sleep ignores all but wake instruction.
// - Busy bit high during write operations.
// - Three guard bits select guarded span.
// - End select picks top or bottom span.
// - Lock bit plus low pin refuses status write.
// - Reserved status bit reads zero.
// - Sixteen block part guard code table.
// - Eight block part guard code table.
// - Four block part guard code table.
// - Two block part guard code table.
// - Select fall starts frame, first byte opcode.
// - Status write changes bits 7,5,4,3,2 only.
`timescale 1ns/1ns
`include "sfg_defines.svh"
module sfg_top
  import sfg_pkg::*;
#(
  parameter int BLOCKS = 16,
  parameter int PUW_CYCLES = `SFG_PUW_CYC,
  parameter int OP_CYCLES = `SFG_OP_CYC
) (
  // System clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Serial link.
  input wire logic i_spi_clk,
  input wire logic i_cs_n,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic i_serial_io_pin,
  output logic o_serial_io_pin,
  output logic o_serial_io_pin_oe,
  output logic o_so,
  output logic o_so_oe,
  // Supply monitor.
  input wire logic i_supply_low,
  // Array side.
  input wire logic [7:0] i_read_byte,
  output logic o_op_start,
  output logic [7:0] o_op_code,
  output logic [23:0] o_op_addr,
  output logic [7:0] o_op_data,
  output logic o_op_refused,
  output logic [7:0] o_status
);
  // ***************************************************************
  // Link domain: shift in on rising edges.
  // ***************************************************************
  logic in_frame_reg;
  logic [11:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] frame_byte [0:4];
  logic [8:0] byte_idx;
  logic [9:0] link_sync;
  logic [7:0] rd_sync;
  logic [7:0] link_status;
  logic link_sleep;
  sfg_state_t state_reg;

  assign byte_idx = bit_cnt_reg[11:3];
  assign link_status = link_sync[7:0];
  assign link_sleep = link_sync[8];

  // Marks that the frame has seen its first rising edge.
  always_ff @(posedge i_spi_clk or posedge i_cs_n)
  begin
    if (i_cs_n)
      in_frame_reg <= 1'b0;
    else if (i_hold_n)
      in_frame_reg <= 1'b1;
  end

  // Bit count restarts at each new frame and is kept afterwards.
  always_ff @(posedge i_spi_clk)
  begin
    if (!i_cs_n && i_hold_n)
    begin
      if (!in_frame_reg)
        bit_cnt_reg <= 12'h001;
      else if (bit_cnt_reg != 12'hfff)
        bit_cnt_reg <= bit_cnt_reg + 12'h001;
    end
  end

  // Input shift, most significant bit first, and byte capture.
  always_ff @(posedge i_spi_clk)
  begin
    if (!i_cs_n && i_hold_n)
    begin
      shift_reg <= {shift_reg[6:0], i_serial_io_pin};
      if (!in_frame_reg)
        frame_byte[0] <= {shift_reg[6:0], i_serial_io_pin};
      else if (bit_cnt_reg[2:0] == 3'd7 && byte_idx < 9'd5)
        frame_byte[byte_idx[2:0]] <= {shift_reg[6:0], i_serial_io_pin};
    end
  end

  // Status, sleep flag and read byte brought into the link domain.
  sfg_sync #(.WIDTH(10)) u_link_sync (
    .i_clk(i_spi_clk),
    .i_d({o_status[`SFG_SR_BUSY], state_reg == sfg_st_sleep, o_status}),
    .o_q(link_sync)
  );

  sfg_sync #(.WIDTH(8)) u_rd_sync (
    .i_clk(i_spi_clk),
    .i_d(i_read_byte),
    .o_q(rd_sync)
  );

  // ***************************************************************
  // Link domain: pause and outputs on falling edges.
  // ***************************************************************
  logic held_reg;
  logic paused;
  logic so_reg;
  logic io_reg;
  logic dual_reg;
  logic stat_mode;
  logic dual_mode;

  // Pause level taken at each falling clock edge.
  always_ff @(negedge i_spi_clk or posedge i_cs_n)
  begin
    if (i_cs_n)
      held_reg <= 1'b0;
    else
      held_reg <= ~i_hold_n;
  end

  // With the clock low the pin acts at once, else after a falling edge.
  assign paused = ~i_cs_n & (i_spi_clk ? held_reg : ~i_hold_n);

  assign stat_mode = (frame_byte[0] == `SFG_OP_STAT_RD) && !link_sleep &&
                     in_frame_reg && (bit_cnt_reg >= `SFG_STAT_START_BITS);
  assign dual_mode = (frame_byte[0] == `SFG_OP_DUAL_RD) && !link_sleep &&
                     !link_sync[9] && in_frame_reg && (bit_cnt_reg >= `SFG_DUAL_START_BITS);

  // Output bits change on falling edges and clear at deselect, frozen while paused.
  always_ff @(negedge i_spi_clk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      so_reg <= 1'b0;
      io_reg <= 1'b0;
      dual_reg <= 1'b0;
    end
    else if (!held_reg)
    begin
      if (dual_mode)
      begin
        so_reg <= rd_sync[{~bit_cnt_reg[1:0], 1'b1}];
        io_reg <= rd_sync[{~bit_cnt_reg[1:0], 1'b0}];
        dual_reg <= 1'b1;
      end
      else
      begin
        so_reg <= stat_mode ? link_status[~bit_cnt_reg[2:0]] : 1'b0;
        io_reg <= 1'b0;
        dual_reg <= 1'b0;
      end
    end
  end

  // Drivers float when deselected or paused.
  assign o_so = so_reg;
  assign o_so_oe = ~i_cs_n & ~paused;
  assign o_serial_io_pin = io_reg;
  assign o_serial_io_pin_oe = dual_reg & ~i_cs_n & ~paused;

  // ***************************************************************
  // System domain: pins, frame end and decode.
  // ***************************************************************
  logic cs_s;
  logic wp_s;
  logic low_s;
  logic cs_d_reg;
  logic armed_reg;
  logic frame_end;
  logic whole_bytes;
  logic [8:0] nbytes;
  logic [7:0] op;
  logic [23:0] addr;
  logic hit;
  logic any_guard;
  logic [2:0] guard_reg;
  logic low_end_reg;

  sfg_sync #(.WIDTH(3)) u_pin_sync (
    .i_clk(i_sys_clk),
    .i_d({i_cs_n, i_wp_n, i_supply_low}),
    .o_q({cs_s, wp_s, low_s})
  );

  // Select edge history and arming by a falling select.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      cs_d_reg <= 1'b1;
      armed_reg <= 1'b0;
    end
    else
    begin
      cs_d_reg <= cs_s;
      if (!cs_s && cs_d_reg)
        armed_reg <= 1'b1;
      else if (low_s)
        armed_reg <= 1'b0;
    end
  end

  assign frame_end = cs_s && !cs_d_reg && armed_reg;
  assign whole_bytes = (bit_cnt_reg[2:0] == 3'd0);
  assign nbytes = bit_cnt_reg[11:3];
  assign op = frame_byte[0];
  assign addr = {frame_byte[1], frame_byte[2], frame_byte[3]};

  sfg_guard #(.BLOCKS(BLOCKS)) u_guard (
    .i_guard(guard_reg),
    .i_from_low(low_end_reg),
    .i_block(addr[19:16]),
    .o_hit(hit),
    .o_any(any_guard)
  );

  // ***************************************************************
  // System domain: state machine and status bits.
  // ***************************************************************
  logic [15:0] cnt_reg;
  logic unlock_reg;
  logic lock_reg;
  logic is_write;
  logic is_array;
  logic target_hit;
  logic wr_ok;
  logic sr_refused;

  always_comb
  begin
    is_array = 1'b0;
    target_hit = 1'b0;
    unique case (op)
      `SFG_OP_PROG:
      begin
        is_array = (nbytes >= 9'd5);
        target_hit = hit;
      end
      `SFG_OP_SECT_ER, `SFG_OP_BLK_ER:
      begin
        is_array = (nbytes == 9'd4);
        target_hit = hit;
      end
      `SFG_OP_CHIP_ER_A, `SFG_OP_CHIP_ER_B:
      begin
        is_array = (nbytes == 9'd1);
        target_hit = any_guard;
      end
      default:
      begin
        is_array = 1'b0;
        target_hit = 1'b0;
      end
    endcase
  end

  assign is_write = (op == `SFG_OP_STAT_WR) && (nbytes == 9'd2);
  assign sr_refused = lock_reg && !wp_s;
  assign wr_ok = frame_end && whole_bytes && unlock_reg &&
                 (state_reg == sfg_st_ready);

  // Protection state and operation timer.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || low_s)
    begin
      state_reg <= sfg_st_inhibit;
      cnt_reg <= 16'(PUW_CYCLES);
    end
    else
    begin
      unique case (state_reg)
        sfg_st_inhibit:
        begin
          if (cnt_reg <= 16'd1)
            state_reg <= sfg_st_ready;
          else
            cnt_reg <= cnt_reg - 16'd1;
        end
        sfg_st_ready:
        begin
          if (frame_end && whole_bytes && op == `SFG_OP_SLEEP && nbytes == 9'd1)
            state_reg <= sfg_st_sleep;
          else if (wr_ok && ((is_write && !sr_refused) || (is_array && !target_hit)))
          begin
            state_reg <= sfg_st_busy;
            cnt_reg <= 16'(OP_CYCLES);
          end
        end
        sfg_st_busy:
        begin
          if (cnt_reg <= 16'd1)
            state_reg <= sfg_st_ready;
          else
            cnt_reg <= cnt_reg - 16'd1;
        end
        sfg_st_sleep:
        begin
          if (frame_end && op == `SFG_OP_WAKE)
            state_reg <= sfg_st_ready;
        end
      endcase
    end
  end

  // Write unlock latch.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || low_s)
      unlock_reg <= 1'b0;
    else if (state_reg == sfg_st_busy && cnt_reg <= 16'd1)
      unlock_reg <= 1'b0;
    else if (frame_end && whole_bytes && nbytes == 9'd1 &&
             state_reg == sfg_st_ready)
    begin
      if (op == `SFG_OP_UNLOCK)
        unlock_reg <= 1'b1;
      else if (op == `SFG_OP_RELOCK)
        unlock_reg <= 1'b0;
    end
  end

  // Writable status fields; only the masked positions change.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      guard_reg <= 3'h0;
      low_end_reg <= 1'b0;
      lock_reg <= 1'b0;
    end
    else if (wr_ok && is_write && !sr_refused && !low_s)
    begin
      guard_reg <= frame_byte[1][`SFG_SR_GUARD_HI:`SFG_SR_GUARD_LO];
      low_end_reg <= frame_byte[1][`SFG_SR_LOW_END];
      lock_reg <= frame_byte[1][`SFG_SR_LOCK];
    end
  end

  // Array operation request, suppressed for guarded targets.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_op_start <= 1'b0;
      o_op_refused <= 1'b0;
      o_op_code <= 8'h00;
      o_op_addr <= 24'h000000;
      o_op_data <= 8'h00;
    end
    else
    begin
      o_op_start <= wr_ok && is_array && !target_hit && !low_s;
      o_op_refused <= wr_ok && is_array && target_hit;
      if (wr_ok && is_array)
      begin
        o_op_code <= op;
        o_op_addr <= addr;
        o_op_data <= frame_byte[4];
      end
    end
  end

  // Status register image; reserved bit reads zero.
  assign o_status = {lock_reg, 1'b0, low_end_reg, guard_reg, unlock_reg,
                     state_reg == sfg_st_busy};

  // ***************************************************************
  // Assertions and covers.
  // ***************************************************************
  a_unlock_sets: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (frame_end && whole_bytes && nbytes == 9'd1 && op == `SFG_OP_UNLOCK &&
     state_reg == sfg_st_ready && !low_s) |=> unlock_reg)
    else $error("unlock latch not set");
  a_done_relocks: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $fell(o_status[`SFG_SR_BUSY]) && !low_s |-> !unlock_reg)
    else $error("unlock latch kept after operation");
  a_low_inhibits: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    low_s |=> state_reg == sfg_st_inhibit && !unlock_reg)
    else $error("low supply not inhibiting");
  a_rsvd_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !o_status[`SFG_SR_RSVD])
    else $error("reserved status bit set");
  a_lock_holds: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (frame_end && is_write && lock_reg && !wp_s) |=> $stable(o_status[7:2]))
    else $error("locked status write took effect");
  a_start_unlocked: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_op_start |-> $past(unlock_reg) && o_status[`SFG_SR_BUSY])
    else $error("operation started without unlock");
  a_guard_blocks: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_op_refused |-> !o_op_start && !o_status[`SFG_SR_BUSY])
    else $error("guarded target altered");
  a_powerup_quiet: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    state_reg == sfg_st_inhibit |=> !o_op_start && !$rose(unlock_reg))
    else $error("write accepted during power-up delay");
  a_sleep_stays: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state_reg == sfg_st_sleep && frame_end && op != `SFG_OP_WAKE && !low_s)
    |=> state_reg == sfg_st_sleep)
    else $error("sleep left without wake");
  a_pause_freezes: assert property (@(posedge i_spi_clk) disable iff (i_cs_n)
    (!i_hold_n && in_frame_reg) |=> bit_cnt_reg == $past(bit_cnt_reg))
    else $error("bit count moved while paused");
  a_dual_only: assert property (@(negedge i_spi_clk) disable iff (i_cs_n)
    dual_reg |-> frame_byte[0] == `SFG_OP_DUAL_RD)
    else $error("second output outside dual read");
  c_status_write: cover property (@(posedge i_sys_clk) wr_ok && is_write && !sr_refused);
  c_op_start: cover property (@(posedge i_sys_clk) o_op_start);
  c_dual_read: cover property (@(negedge i_spi_clk) dual_reg);
  c_pause: cover property (@(posedge i_spi_clk) !i_cs_n && !i_hold_n && in_frame_reg);
endmodule : sfg_top

// ==== dv/sfg_spi_master.sv ====
// Serial bus controller model that drives the flash front end.
`timescale 1ns/1ns
module sfg_spi_master (
  // Controller outputs.
  output logic o_spi_clk,
  output logic o_cs_n,
  output logic o_hold_n,
  output logic o_mosi,
  // Lines from the device.
  input wire logic i_so,
  input wire logic i_io
);
  // ****************************************
  // Link state
  // ****************************************
  logic idle_high;
  logic [7:0] so_q;
  logic [7:0] io_q;

  // Deselected bus with the clock standing still at the low level.
  initial
  begin
    o_spi_clk = 1'b0;
    o_cs_n = 1'b1;
    o_hold_n = 1'b1;
    o_mosi = 1'b0;
    idle_high = 1'b0;
    so_q = 8'h00;
    io_q = 8'h00;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  // Picks the idle clock level, only between frames.
  task automatic set_mode(input logic high);
    idle_high = high;
    o_spi_clk = high;
  endtask : set_mode

  // Selects the device; the clock stays at its idle level.
  task automatic begin_frame();
    #7 o_cs_n = 1'b0;
  endtask : begin_frame

  // One period: data set after the fall, both lines taken at the rise.
  task automatic bit_out(input logic b, input logic drive);
    #20 o_spi_clk = 1'b0;
    o_mosi = drive ? b : ~o_mosi;
    #40 o_spi_clk = 1'b1;
    so_q = {so_q[6:0], i_so};
    io_q = {io_q[6:0], i_io};
    #20;
  endtask : bit_out

  // Returns the clock to idle, deselects and lets the data line wander.
  task automatic end_frame();
    #20 o_spi_clk = idle_high;
    #20 o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
  endtask : end_frame

  // Pause pin; select is never touched here, so it stays low throughout.
  task automatic pause(input logic run);
    o_hold_n = run;
  endtask : pause
endmodule : sfg_spi_master

// ==== dv/sfg_top_tb.sv ====
// Self-checking bench of the serial flash front end and write guard.
`timescale 1ns/1ns
module sfg_top_tb;
  // ****************************************
  // Signals
  // ****************************************
  localparam int PUW = 40;
  localparam int OPC = 20;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_wp_n = 1'b1;
  logic i_supply_low = 1'b0;
  logic [7:0] i_read_byte = 8'h00;
  logic spi_clk, cs_n, hold_n, mosi, io_wire, so_wire;
  logic dut_io, dut_io_oe, dut_so, dut_so_oe, op_start, op_refused;
  logic [7:0] op_code, op_data, status;
  logic [23:0] op_addr;
  logic [7:0] tx[$];
  int fail_count = 0;
  int checks = 0;
  int starts = 0;
  int refusals = 0;

  // System clock, 40 ns period.
  always #20 i_sys_clk = ~i_sys_clk;

  // Shared data line: whoever enables drives; a floating so output reads back inverted.
  assign io_wire = dut_io_oe ? dut_io : mosi;
  assign so_wire = dut_so_oe ? dut_so : ~dut_so;

  // Counts the array-side pulses.
  always @(posedge i_sys_clk)
  begin
    if (op_start === 1'b1)
      starts++;
    if (op_refused === 1'b1)
      refusals++;
  end

  sfg_top #(.BLOCKS(16), .PUW_CYCLES(PUW), .OP_CYCLES(OPC)) sfg_top_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_spi_clk(spi_clk), .i_cs_n(cs_n),
    .i_hold_n(hold_n), .i_wp_n(i_wp_n), .i_serial_io_pin(io_wire),
    .o_serial_io_pin(dut_io), .o_serial_io_pin_oe(dut_io_oe), .o_so(dut_so),
    .o_so_oe(dut_so_oe), .i_supply_low(i_supply_low), .i_read_byte(i_read_byte),
    .o_op_start(op_start), .o_op_code(op_code), .o_op_addr(op_addr),
    .o_op_data(op_data), .o_op_refused(op_refused), .o_status(status)
  );

  sfg_spi_master sfg_spi_master_inst (
    .o_spi_clk(spi_clk), .o_cs_n(cs_n), .o_hold_n(hold_n), .o_mosi(mosi),
    .i_so(so_wire), .i_io(io_wire)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Compares and counts.
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Prints the verdict and stops.
  task automatic print_verdict();
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic cycles(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : cycles

  task automatic send(input logic [7:0] b);
    for (int k = 7; k >= 0; k--)
      sfg_spi_master_inst.bit_out(b[k], 1'b1);
  endtask : send

  // Sends the queued bytes as one frame and lets its effect land.
  task automatic cmd();
    sfg_spi_master_inst.begin_frame();
    foreach (tx[i])
      send(tx[i]);
    sfg_spi_master_inst.end_frame();
    cycles(8);
  endtask : cmd

  // One status read frame over the link.
  task automatic rd_link();
    sfg_spi_master_inst.begin_frame();
    send(8'h05);
    repeat (8) sfg_spi_master_inst.bit_out(1'b0, 1'b0);
    sfg_spi_master_inst.end_frame();
    cycles(8);
  endtask : rd_link

  // Reads status over the link and at the port.
  task automatic rd_status(input logic [7:0] exp);
    rd_link();
    check(24'(sfg_spi_master_inst.so_q), 24'(exp));
    check(24'(status), 24'(exp));
  endtask : rd_status

  // Waits for the busy bit to drop, bounded.
  task automatic wait_idle();
    int n = 0;
    while (status[0] !== 1'b0)
    begin
      n++;
      if (n > 200)
      begin
        check(24'(status), 24'h0);
        break;
      end
      @(negedge i_sys_clk);
    end
  endtask : wait_idle

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_powerup();
    tx = '{8'h06};
    cmd();
    rd_status(8'h00);
    cycles(PUW);
  endtask : t_powerup

  task automatic t_status_write();
    tx = '{8'h06};
    cmd();
    rd_status(8'h02);
    tx = '{8'h01, 8'hfe};
    cmd();
    check(24'(status[1:0]), 24'h3);
    wait_idle();
    rd_status(8'hbc);
  endtask : t_status_write

  task automatic t_lock();
    sfg_spi_master_inst.set_mode(1'b1);
    i_wp_n = 1'b0;
    tx = '{8'h06};
    cmd();
    tx = '{8'h01, 8'h00};
    cmd();
    wait_idle();
    rd_status(8'hbe);
    i_wp_n = 1'b1;
    tx = '{8'h01, 8'h04};
    cmd();
    wait_idle();
    rd_status(8'h04);
    sfg_spi_master_inst.set_mode(1'b0);
  endtask : t_lock

  task automatic t_guard();
    tx = '{8'h06};
    cmd();
    tx = '{8'h02, 8'h0f, 8'h00, 8'h10, 8'h5a};
    cmd();
    check(24'(refusals), 24'h1);
    check(op_addr, 24'h0f0010);
    check(24'(op_code), 24'h02);
    rd_status(8'h06);
    tx = '{8'h02, 8'h0e, 8'hff, 8'h00, 8'h3c};
    cmd();
    check(24'(starts), 24'h1);
    check(24'(op_data), 24'h3c);
    wait_idle();
    rd_status(8'h04);
    tx = '{8'h06};
    cmd();
    tx = '{8'h01, 8'h24};
    cmd();
    wait_idle();
    tx = '{8'h06};
    cmd();
    tx = '{8'h20, 8'h00, 8'h80, 8'h00};
    cmd();
    check(24'(refusals), 24'h2);
    tx = '{8'hc7};
    cmd();
    check(24'(refusals), 24'h3);
    check(24'(op_code), 24'hc7);
  endtask : t_guard

  task automatic t_hold();
    logic [7:0] op = 8'h05;
    sfg_spi_master_inst.begin_frame();
    for (int k = 7; k >= 4; k--)
      sfg_spi_master_inst.bit_out(op[k], 1'b1);
    sfg_spi_master_inst.pause(1'b0);
    sfg_spi_master_inst.bit_out(1'b1, 1'b1);
    sfg_spi_master_inst.bit_out(1'b1, 1'b1);
    check(24'(dut_so_oe), 24'h0);
    check(24'(dut_io_oe), 24'h0);
    sfg_spi_master_inst.pause(1'b1);
    for (int k = 3; k >= 0; k--)
      sfg_spi_master_inst.bit_out(op[k], 1'b1);
    repeat (8) sfg_spi_master_inst.bit_out(1'b0, 1'b0);
    sfg_spi_master_inst.end_frame();
    cycles(8);
    check(24'(sfg_spi_master_inst.so_q), 24'h26);
  endtask : t_hold

  task automatic t_sleep();
    tx = '{8'hb9};
    cmd();
    tx = '{8'h04};
    cmd();
    check(24'(status), 24'h26);
    rd_link();
    check(24'(sfg_spi_master_inst.so_q), 24'h00);
    tx = '{8'hab};
    cmd();
    tx = '{8'h04};
    cmd();
    rd_status(8'h24);
  endtask : t_sleep

  task automatic t_dual();
    i_read_byte = 8'h96;
    cycles(2);
    sfg_spi_master_inst.begin_frame();
    send(8'h3b);
    repeat (4) send(8'h00);
    repeat (4) sfg_spi_master_inst.bit_out(1'b0, 1'b0);
    sfg_spi_master_inst.end_frame();
    cycles(8);
    check(24'(sfg_spi_master_inst.so_q[3:0]), 24'h9);
    check(24'(sfg_spi_master_inst.io_q[3:0]), 24'h6);
  endtask : t_dual

  task automatic t_supply();
    tx = '{8'h06};
    cmd();
    check(24'(status[1]), 24'h1);
    i_supply_low = 1'b1;
    cycles(4);
    check(24'(status[1]), 24'h0);
    cmd();
    check(24'(status[1]), 24'h0);
  endtask : t_supply

  // Main sequence: reset for five cycles, then every scenario in turn.
  initial
  begin
    cycles(5);
    i_reset = 1'b0;
    cycles(4);
    t_powerup();
    t_status_write();
    t_lock();
    t_guard();
    t_hold();
    t_sleep();
    t_dual();
    t_supply();
    print_verdict();
  end
endmodule : sfg_top_tb
